// ==== core/tg_defines.vh ====
`ifndef TG_DEFINES_VH
`define TG_DEFINES_VH

// ----------------------------------------
// rate gate
// ----------------------------------------
`define TG_RATE_PERIOD    7'd100
`define TG_RATE_ONE       7'd1

// ----------------------------------------
// pattern encodings
// ----------------------------------------
`define TG_PAT_ZERO       3'h0
`define TG_PAT_ONE        3'h1
`define TG_PAT_INC        3'h2
`define TG_PAT_DEC        3'h3
`define TG_PAT_LFSR       3'h4

// ----------------------------------------
// block layout: 16 words of 32 bytes per 512-byte block
// ----------------------------------------
`define TG_WORDS_PER_BLK_LOG2 4
`define TG_BLK_LAST       4'hF
`define TG_SECT_HI_PAD    16'h0000

// ----------------------------------------
// lfsr seeds for the two 128-bit halves
// ----------------------------------------
`define TG_SEED_MASK_LO   32'h0000FFFF
`define TG_SEED_MASK_HI   32'hFFFF0000
// all-zero and all-ones are both fixed points of the recurrence; bit 0 set, bit 30 clear avoids them
`define TG_SEED_SET       32'h00000001
`define TG_SEED_CLR       32'h40000000

`endif

// ==== core/tg_traffic_gen.v ====
`timescale 1ns/1ns
`include "tg_defines.vh"

// Summary of operation
// - gate high rate_setting cycles per hundred
// - rate counter runs only while transfer active
// - no push or pop while gate low
// - push when not nearly full and gated
// - pop when not empty and gated
// - accept length, sector, pattern, rate, direction, verify
// - length converted to end count
// - count words, stop at end count
// - five selectable patterns
// - constant patterns carry no header
// - counting patterns: 64-bit header per block
// - header dwords hold sector index bits
// - write data is 256-bit per push
// - compare popped word with expected word
// - mismatch raises fail flag
// - sector index loads start, increments per block
// - lfsr polynomial x31+x21+x+1
// - increment from counter, decrement inverts it
module tg_traffic_gen #(
  parameter LEN_W  = 32,
  parameter SECT_W = 48,
  parameter DATA_W = 256
) (
  input  wire              core_clk_in,
  input  wire              sys_rst_in,
  input  wire              start_in,
  input  wire              direction_read_in,
  input  wire              verify_enable_in,
  input  wire [LEN_W-1:0]  transfer_length_in,
  input  wire [SECT_W-1:0] start_sector_in,
  input  wire [2:0]        pattern_choice_in,
  input  wire [6:0]        rate_setting_in,
  input  wire              wr_fifo_nearly_full_in,
  output reg               wr_fifo_push_out,
  output reg  [DATA_W-1:0] wr_fifo_data_out,
  input  wire              rd_fifo_has_none_in,
  input  wire [DATA_W-1:0] rd_fifo_data_in,
  output wire              rd_fifo_pop_out,
  output reg               write_active_out,
  output reg               read_active_out,
  output reg               mismatch_flag_out,
  output reg  [LEN_W-1:0]  moved_count_out
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [6:0]        rate_cycle_count;
  reg               rate_gate;
  reg               next_rate_gate;
  reg  [LEN_W-1:0]  end_count;
  reg  [SECT_W-1:0] sector_index;
  reg  [LEN_W-1:0]  gen_count;
  reg  [31:0]       lfsr_lo;
  reg  [31:0]       lfsr_hi;
  reg               pop_d1;
  reg               pop_d2;
  reg  [DATA_W-1:0] rd_data_d;
  reg  [2:0]        pattern_sel;
  reg               verify_en;
  wire              active;
  wire              gen_step;
  wire              next_wr_fifo_push;
  wire              blk_first;
  wire              blk_last;
  reg  [DATA_W-1:0] expected;
  reg  [DATA_W-1:0] exp_d1;
  reg  [DATA_W-1:0] exp_d2;
  reg  [127:0]      lfsr_lo_w;
  reg  [127:0]      lfsr_hi_w;
  reg  [31:0]       next_lfsr_lo;
  reg  [31:0]       next_lfsr_hi;
  integer           i;

  assign active = write_active_out | read_active_out;

  // ----------------------------------------
  // rate gate
  // ----------------------------------------
  // counter runs only when active
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in || !active)
      rate_cycle_count <= `TG_RATE_PERIOD;
    else if (rate_cycle_count == `TG_RATE_PERIOD)
      rate_cycle_count <= `TG_RATE_ONE;
    else
      rate_cycle_count <= rate_cycle_count + `TG_RATE_ONE;
  end

  // gate open for rate_setting cycles of each hundred
  always @*
  begin
    next_rate_gate = rate_gate;
    if (!active)
      next_rate_gate = 1'b0;
    else if (rate_cycle_count == `TG_RATE_PERIOD)
      next_rate_gate = (rate_setting_in != 7'h00);
    else if (rate_cycle_count >= rate_setting_in)
      next_rate_gate = 1'b0;
  end

  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      rate_gate <= 1'b0;
    else
      rate_gate <= next_rate_gate;
  end

  // ----------------------------------------
  // transfer control
  // ----------------------------------------
  // pop when data present and gate open, read fifo
  // no pop beyond the end count
  assign rd_fifo_pop_out = read_active_out & rate_gate & ~rd_fifo_has_none_in &
                           (gen_count < end_count);

  // words are generated when a push is decided, or on a pop for the expected word
  assign gen_step  = next_wr_fifo_push | rd_fifo_pop_out;
  assign blk_first = (gen_count[`TG_WORDS_PER_BLK_LOG2-1:0] == 4'h0);
  assign blk_last  = (gen_count[`TG_WORDS_PER_BLK_LOG2-1:0] == `TG_BLK_LAST);

  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      write_active_out <= 1'b0;
      read_active_out  <= 1'b0;
      end_count        <= {LEN_W{1'b0}};
      pattern_sel      <= `TG_PAT_ZERO;
      verify_en        <= 1'b0;
    end
    else if (start_in && !active)
    begin
      write_active_out <= ~direction_read_in & (transfer_length_in != {LEN_W{1'b0}});
      read_active_out  <= direction_read_in & (transfer_length_in != {LEN_W{1'b0}});
      // length in 512-byte blocks times 16 words
      end_count   <= transfer_length_in << `TG_WORDS_PER_BLK_LOG2;
      pattern_sel <= pattern_choice_in;
      verify_en   <= verify_enable_in;
    end
    else
    begin
      if (write_active_out && wr_fifo_push_out && (moved_count_out + 1'b1 == end_count))
        write_active_out <= 1'b0;
      if (read_active_out && pop_d2 && (moved_count_out + 1'b1 == end_count))
        read_active_out <= 1'b0;
    end
  end

  // push decision, uses the gate it will meet, stops at end
  assign next_wr_fifo_push = write_active_out & next_rate_gate & ~wr_fifo_nearly_full_in &
                             (gen_count < end_count);

  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      wr_fifo_push_out <= 1'b0;
    else
      wr_fifo_push_out <= next_wr_fifo_push;
  end

  // moved count, read side counts two cycles after pop
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in || (start_in && !active))
      moved_count_out <= {LEN_W{1'b0}};
    else if ((write_active_out && wr_fifo_push_out) || (read_active_out && pop_d2))
      moved_count_out <= moved_count_out + 1'b1;
  end

  // ----------------------------------------
  // pattern generator
  // ----------------------------------------
  // four look-ahead steps of x31+x21+x+1 per half
  always @*
  begin
    next_lfsr_lo = lfsr_lo;
    next_lfsr_hi = lfsr_hi;
    lfsr_lo_w    = 128'h0;
    lfsr_hi_w    = 128'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      lfsr_lo_w[i*32 +: 32] = next_lfsr_lo;
      lfsr_hi_w[i*32 +: 32] = next_lfsr_hi;
      next_lfsr_lo = {next_lfsr_lo[30:0], next_lfsr_lo[30] ^ next_lfsr_lo[20] ^ next_lfsr_lo[0]};
      next_lfsr_hi = {next_lfsr_hi[30:0], next_lfsr_hi[30] ^ next_lfsr_hi[20] ^ next_lfsr_hi[0]};
    end
  end

  always @*
  begin
    expected = {DATA_W{1'b0}};
    case (pattern_sel)
      `TG_PAT_ZERO: expected = {DATA_W{1'b0}};
      `TG_PAT_ONE:  expected = {DATA_W{1'b1}};
      `TG_PAT_INC:  expected = {8{gen_count[31:0]}};
      `TG_PAT_DEC:  expected = ~{8{gen_count[31:0]}};
      `TG_PAT_LFSR: expected = {lfsr_hi_w, lfsr_lo_w};
      default:      expected = {DATA_W{1'b0}};
    endcase
    if ((pattern_sel == `TG_PAT_INC || pattern_sel == `TG_PAT_DEC ||
         pattern_sel == `TG_PAT_LFSR) && blk_first)
      expected[63:0] = {`TG_SECT_HI_PAD, sector_index[47:32], sector_index[31:0]};
  end

  // sector index loads start, advances per block
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      gen_count    <= {LEN_W{1'b0}};
      sector_index <= {SECT_W{1'b0}};
      lfsr_lo      <= 32'h0;
      lfsr_hi      <= 32'h0;
    end
    else if (start_in && !active)
    begin
      gen_count    <= {LEN_W{1'b0}};
      sector_index <= start_sector_in;
      // seeds mix the sector with its inverse; forced bits keep them off the fixed points
      lfsr_lo <= ((start_sector_in[31:0] & `TG_SEED_MASK_LO) |
                  (~start_sector_in[31:0] & `TG_SEED_MASK_HI) | `TG_SEED_SET) & ~`TG_SEED_CLR;
      lfsr_hi <= ((~start_sector_in[31:0] & `TG_SEED_MASK_LO) |
                  (start_sector_in[31:0] & `TG_SEED_MASK_HI) | `TG_SEED_SET) & ~`TG_SEED_CLR;
    end
    else if (gen_step)
    begin
      gen_count <= gen_count + 1'b1;
      lfsr_lo   <= next_lfsr_lo;
      lfsr_hi   <= next_lfsr_hi;
      if (blk_last)
        sector_index <= sector_index + 1'b1;
    end
  end

  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      wr_fifo_data_out <= {DATA_W{1'b0}};
    else if (next_wr_fifo_push)
      wr_fifo_data_out <= expected;
  end

  // ----------------------------------------
  // read check
  // ----------------------------------------
  // read data is taken one cycle after pop and compared on the next
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      pop_d1    <= 1'b0;
      pop_d2    <= 1'b0;
      rd_data_d <= {DATA_W{1'b0}};
      exp_d1    <= {DATA_W{1'b0}};
      exp_d2    <= {DATA_W{1'b0}};
    end
    else
    begin
      pop_d1    <= rd_fifo_pop_out;
      pop_d2    <= pop_d1;
      rd_data_d <= rd_fifo_data_in;
      exp_d1    <= expected;
      exp_d2    <= exp_d1;
    end
  end

  // compare, raise flag, sticky and verify gated
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in || (start_in && !active))
      mismatch_flag_out <= 1'b0;
    else if (pop_d2 && verify_en && (rd_data_d != exp_d2))
      mismatch_flag_out <= 1'b1;
  end

endmodule

// ==== dv/tg_traffic_gen_assertions.sv ====
`timescale 1ns/1ns
module tg_traffic_gen_assertions (
  input wire        core_clk_in,
  input wire        sys_rst_in,
  input wire        start_in,
  input wire        direction_read_in,
  input wire [31:0] transfer_length_in,
  input wire [6:0]  rate_setting_in,
  input wire        wr_fifo_nearly_full_in,
  input wire        wr_fifo_push_out,
  input wire        rd_fifo_has_none_in,
  input wire        rd_fifo_pop_out,
  input wire        write_active_out,
  input wire        read_active_out,
  input wire        mismatch_flag_out,
  input wire [31:0] moved_count_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire idle = !write_active_out && !read_active_out;
  wire go   = start_in && idle && transfer_length_in != 32'h0;
  AST_PUSH_GATED: assert property (
    wr_fifo_push_out |-> $past(write_active_out && !wr_fifo_nearly_full_in)) else $error("bad push");
  AST_POP_GATED: assert property (
    rd_fifo_pop_out |-> read_active_out && !rd_fifo_has_none_in) else $error("bad pop");
  AST_START_DIR: assert property (
    go |=> read_active_out == $past(direction_read_in) && write_active_out != $past(direction_read_in))
    else $error("start not taken");
  AST_GATE_WAIT: assert property (
    go && !direction_read_in |=> !wr_fifo_push_out ##1
    (wr_fifo_push_out == ($past(rate_setting_in) != 7'h00 && !$past(wr_fifo_nearly_full_in))))
    else $error("first push not on gate opening");
  AST_COUNT_STEP: assert property (
    moved_count_out != $past(moved_count_out) && !$past(start_in) && !$past(start_in, 2)
    |-> moved_count_out == $past(moved_count_out) + 32'h1) else $error("count jump");
  AST_END_IDLE: assert property (
    !write_active_out && !$past(write_active_out) |-> !wr_fifo_push_out) else $error("push idle");
  AST_FAIL_HOLD: assert property (
    mismatch_flag_out && !start_in |=> mismatch_flag_out) else $error("fail flag dropped");
  AST_FAIL_SRC: assert property (
    $rose(mismatch_flag_out) |-> $past(read_active_out)) else $error("fail outside read");
  cover property (go && direction_read_in);
  cover property ($rose(mismatch_flag_out));
  cover property (write_active_out && wr_fifo_nearly_full_in);
endmodule

// ==== dv/tg_fifo_model.sv ====
`timescale 1ns/1ns
// loopback: words pushed by a write come back on the next read
module tg_fifo_model #(
  parameter LIMIT = 40
) (
  input  wire         core_clk_in,
  input  wire         stall_in,
  input  wire         flip_in,
  input  wire         push_in,
  input  wire [255:0] push_data_in,
  input  wire         pop_in,
  output wire         nearly_full_out,
  output wire         has_none_out,
  output reg  [255:0] pop_data_out
);
  logic [255:0] q[$];
  int           fill = 0;
  assign nearly_full_out = stall_in || fill >= LIMIT;
  assign has_none_out = fill == 0;
  initial pop_data_out = 256'h0;
  always @(posedge core_clk_in)
  begin
    if (push_in)
      q.push_back(push_data_in);
    // outside a pop the data turns over so stale words never match
    if (pop_in && q.size() != 0)
      pop_data_out <= q.pop_front() ^ {255'h0, flip_in};
    else
      pop_data_out <= ~pop_data_out;
    fill <= q.size();
  end
endmodule

// ==== dv/tg_traffic_gen_bench.sv ====
`timescale 1ns/1ns
module tg_traffic_gen_bench;
  logic         clk = 0, rst = 1, start = 0, dir = 0, ver = 0, stall = 0, flip = 0;
  logic [31:0]  len = 32'h2;
  logic [47:0]  sect = 48'hA5000000FFFF;
  logic [2:0]   pat = 3'h0;
  logic [6:0]   rate = 7'h64;
  wire          nf, push, none, pop, wact, ract, mis;
  wire  [255:0] wdata, rdata;
  wire  [31:0]  moved;
  logic [255:0] w[0:31];
  int           fail_count = 0, n_tests = 0, widx = 0, cyc = 0;
  always #5 clk = ~clk;
  tg_traffic_gen u_dut (.core_clk_in(clk), .sys_rst_in(rst), .start_in(start),
    .direction_read_in(dir), .verify_enable_in(ver), .transfer_length_in(len),
    .start_sector_in(sect), .pattern_choice_in(pat), .rate_setting_in(rate),
    .wr_fifo_nearly_full_in(nf), .wr_fifo_push_out(push), .wr_fifo_data_out(wdata),
    .rd_fifo_has_none_in(none), .rd_fifo_data_in(rdata), .rd_fifo_pop_out(pop),
    .write_active_out(wact), .read_active_out(ract), .mismatch_flag_out(mis),
    .moved_count_out(moved));
  tg_fifo_model u_fifo (.core_clk_in(clk), .stall_in(stall), .flip_in(flip), .push_in(push),
    .push_data_in(wdata), .pop_in(pop), .nearly_full_out(nf), .has_none_out(none),
    .pop_data_out(rdata));
  always @(posedge clk)
  begin
    if (push && widx < 32)
      w[widx] <= wdata;
    if (push)
      widx <= widx + 1;
    if (wact || ract)
      cyc <= cyc + 1;
  end
  task automatic chk(input string nm, input logic [255:0] exp, input logic [255:0] got);
  begin
    n_tests++;
    if (exp !== got)
    begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  end
  endtask
  task automatic run(input logic rd, input logic [2:0] p, input logic [6:0] r);
    int t;
  begin
    t = 0;
    @(posedge clk) #1;
    start = 1;
    dir = rd;
    pat = p;
    rate = r;
    widx = 0;
    cyc = 0;
    @(posedge clk) #1;
    start = 0;
    @(posedge clk) #1;
    while ((wact || ract) && t < 3000)
    begin
      @(posedge clk) #1;
      t++;
    end
    chk("done", 1, t < 3000);
    chk("moved", 32'h20, moved);
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  initial
  begin
    #300000;
    fail_count++;
    close_out;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rst = 0;
    ver = 1;
    for (int p = 0; p < 5; p++)
    begin
      run(0, p, p == 0 ? 7'hA : 7'h64);
      if (p == 0) chk("zeros", 0, w[0]);
      if (p == 0) chk("slow", 1, cyc >= 300);
      if (p == 1) chk("ones", '1, w[0]);
      if (p == 1) chk("fast", 1, cyc <= 40);
      if (p >= 2) chk("hdr", {16'h0, sect}, w[0][63:0]);
      if (p >= 2) chk("hdr next", {16'h0, sect + 48'h1}, w[16][63:0]);
      if (p == 2) chk("inc", {8{32'h00000001}}, w[1]);
      if (p == 2) chk("inc later", {8{32'h00000011}}, w[17]);
      if (p == 3) chk("dec", ~{8{32'h00000001}}, w[1]);
      if (p == 4) chk("lfsr", 1, w[1] !== w[2]);
      flip = (p == 4);
      run(1, p, 7'h64);
      chk("fail flag", p == 4, mis);
      flip = 0;
    end
    fork
      run(0, 3'h2, 7'h64);
      begin
        repeat (6) @(posedge clk) #1;
        stall = 1;
        repeat (30) @(posedge clk) #1;
        stall = 0;
      end
    join
    chk("stalled", 1, cyc >= 55);
    ver = 0;
    flip = 1;
    run(1, 3'h2, 7'h64);
    chk("no verify", 0, mis);
    flip = 0;
    close_out;
  end
endmodule
bind tg_traffic_gen tg_traffic_gen_assertions u_chk (.*);
